//--- design/serial_port_modem_pins.sv
// Two modem serial ports with strap pins and an AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "serial_port_defs.svh"
module serial_port_modem_pins #(
  parameter int DATA_BITS = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic host_bus_reset_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic irq_out,
  input wire logic serial_tx_line_a_in,
  output logic serial_tx_line_a_out,
  output logic serial_tx_line_a_oe_out,
  input wire logic serial_rx_line_a_in,
  input wire logic dtr_a_b_in,
  output logic dtr_a_b_out,
  output logic dtr_a_b_oe_out,
  input wire logic rts_a_b_in,
  output logic rts_a_b_out,
  output logic rts_a_b_oe_out,
  input wire serial_port_pkg::modem_status_pins_t modem_a_in,
  input wire logic serial_tx_line_b_in,
  output logic serial_tx_line_b_out,
  output logic serial_tx_line_b_oe_out,
  input wire logic serial_rx_line_b_in,
  input wire logic dtr_b_b_in,
  output logic dtr_b_b_out,
  output logic dtr_b_b_oe_out,
  input wire logic rts_b_b_in,
  output logic rts_b_b_out,
  output logic rts_b_b_oe_out,
  input wire serial_port_pkg::modem_status_pins_t modem_b_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-port state, plus shared straps and interrupt state

  logic [7:0] ctrl_reg [2];
  serial_port_pkg::line_cfg_t cfg_reg [2];
  logic [DATA_BITS-1:0] tx_data_reg [2];
  logic [1:0] tx_start_reg;
  logic [DATA_BITS-1:0] rx_hold_reg [2];
  logic [1:0] rx_valid_reg;
  logic [3:0] modem_prev_reg [2];
  logic [1:0] tx_oe_reg, tx_pin_reg;
  logic [1:0] dtr_oe_reg, dtr_pin_reg;
  logic [1:0] rts_oe_reg, rts_pin_reg;
  logic [5:0] strap_reg;
  logic [7:0] int_stat_reg, int_mask_reg, int_set;
  logic irq_reg;

  logic [1:0] tx_busy, tx_done, tx_line, rx_done, rx_err, rx_line, loop_on, ir_on;
  logic [DATA_BITS-1:0] rx_data [2];
  logic [3:0] modem_now [2];

  // Active-high view: bit3 carrier, bit2 ring, bit1 clear to send, bit0 set ready
  assign modem_now[0] = ~modem_a_in;
  assign modem_now[1] = ~modem_b_in;
  assign rx_line[0] = loop_on[0] ? tx_line[0] : serial_rx_line_a_in;
  assign rx_line[1] = loop_on[1] ? tx_line[1] : serial_rx_line_b_in;

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign loop_on[p] = ctrl_reg[p][`CTRL_LOOP];
    // Only port B has the infrared modes
    assign ir_on[p] = (p == 1) && ctrl_reg[p][`CTRL_IR];

    serial_tx_engine #(
      .DATA_BITS(DATA_BITS)
    ) u_tx (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .cfg_in(cfg_reg[p]),
      .start_in(tx_start_reg[p]),
      .data_in(tx_data_reg[p]),
      .busy_out(tx_busy[p]),
      .done_out(tx_done[p]),
      .line_out(tx_line[p])
    );

    serial_rx_engine #(
      .DATA_BITS(DATA_BITS)
    ) u_rx (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .cfg_in(cfg_reg[p]),
      .line_in(rx_line[p]),
      .data_out(rx_data[p]),
      .done_out(rx_done[p]),
      .error_out(rx_err[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait, reads take one

  logic acc_take;
  logic wr_pend_reg, rd_pend_reg, ready_reg;
  logic [7:0] wr_addr_reg, rd_addr_reg;
  logic [31:0] rdata_reg, rd_mux;
  logic wr_port, rd_port, wr_in_port, rd_in_port;
  logic [7:0] wr_off, rd_off;

  assign acc_take = hsel_in && htrans_in[1] && hready_in;
  assign wr_port = wr_addr_reg[5];
  assign rd_port = rd_addr_reg[5];
  assign wr_in_port = wr_pend_reg && (wr_addr_reg[7:6] == 2'b00);
  assign rd_in_port = rd_addr_reg[7:6] == 2'b00;
  assign wr_off = {3'b000, wr_addr_reg[4:0]};
  assign rd_off = {3'b000, rd_addr_reg[4:0]};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      ready_reg <= 1'b1;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= acc_take && hwrite_in;
      rd_pend_reg <= acc_take && !hwrite_in;
      if (acc_take && hwrite_in) begin
        wr_addr_reg <= haddr_in[7:0];
      end
      if (acc_take && !hwrite_in) begin
        rd_addr_reg <= haddr_in[7:0];
        ready_reg <= 1'b0;
      end else if (rd_pend_reg) begin
        rdata_reg <= rd_mux;
        ready_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (rd_in_port) begin
      case (rd_off)
        `OFF_CTRL: rd_mux = {24'h00_0000, ctrl_reg[rd_port]};
        `OFF_STAT: begin
          rd_mux[`STAT_TX_BUSY] = tx_busy[rd_port];
          rd_mux[`STAT_RX_VALID] = rx_valid_reg[rd_port];
          rd_mux[`STAT_CTS] = modem_now[rd_port][1];
          rd_mux[`STAT_DSR] = modem_now[rd_port][0];
          rd_mux[`STAT_RI] = modem_now[rd_port][2];
          rd_mux[`STAT_DCD] = modem_now[rd_port][3];
        end
        `OFF_TXD: rd_mux = {{(32 - DATA_BITS){1'b0}}, tx_data_reg[rd_port]};
        `OFF_RXD: rd_mux = {{(32 - DATA_BITS){1'b0}}, rx_hold_reg[rd_port]};
        `OFF_CFG: rd_mux = {13'h0000, cfg_reg[rd_port]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end else begin
      case (rd_addr_reg)
        `OFF_INT_STAT: rd_mux = {24'h00_0000, int_stat_reg};
        `OFF_INT_MASK: rd_mux = {24'h00_0000, int_mask_reg};
        `OFF_STRAPS: rd_mux = {26'h000_0000, strap_reg};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, line settings and transmit data

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      for (int p = 0; p < 2; p++) begin
        ctrl_reg[p] <= `CTRL_RESET;
        cfg_reg[p] <= '{divisor: `DIVISOR_RESET, default: 1'b0};
        tx_data_reg[p] <= '0;
      end
      tx_start_reg <= 2'b00;
    end else begin
      tx_start_reg <= 2'b00;
      if (wr_in_port) begin
        case (wr_off)
          `OFF_CTRL: ctrl_reg[wr_port] <= hwdata_in[7:0];
          `OFF_CFG: cfg_reg[wr_port] <= hwdata_in[18:0];
          // Write while busy is dropped rather than queued
          `OFF_TXD: begin
            if (!tx_busy[wr_port]) begin
              tx_data_reg[wr_port] <= hwdata_in[DATA_BITS-1:0];
              tx_start_reg[wr_port] <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive holding and modem change tracking

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      for (int p = 0; p < 2; p++) begin
        rx_hold_reg[p] <= '0;
        modem_prev_reg[p] <= 4'h0;
      end
      rx_valid_reg <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        modem_prev_reg[p] <= modem_now[p];
        if (rx_done[p]) begin
          rx_hold_reg[p] <= rx_data[p];
          rx_valid_reg[p] <= 1'b1;
        end else if (rd_pend_reg && rd_in_port && rd_off == `OFF_RXD && rd_port == p[0]) begin
          rx_valid_reg[p] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output

  always_comb begin
    int_set = 8'h00;
    for (int p = 0; p < 2; p++) begin
      int_set[p * `INT_PER_PORT + `INT_TX_DONE] = tx_done[p];
      int_set[p * `INT_PER_PORT + `INT_RX_READY] = rx_done[p];
      int_set[p * `INT_PER_PORT + `INT_RX_ERR] = rx_err[p];
      int_set[p * `INT_PER_PORT + `INT_MODEM] = modem_now[p] != modem_prev_reg[p];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      int_stat_reg <= 8'h00;
      int_mask_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      // A new event beats a same-cycle clear
      if (wr_pend_reg && wr_addr_reg == `OFF_INT_STAT) begin
        int_stat_reg <= (int_stat_reg & ~hwdata_in[7:0]) | int_set;
      end else begin
        int_stat_reg <= int_stat_reg | int_set;
      end
      if (wr_pend_reg && wr_addr_reg == `OFF_INT_MASK) begin
        int_mask_reg <= hwdata_in[7:0];
      end
      irq_reg <= |(int_stat_reg & int_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and strap capture

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      tx_pin_reg <= 2'b11;
      dtr_pin_reg <= 2'b11;
      rts_pin_reg <= 2'b11;
      tx_oe_reg <= 2'b00;
      dtr_oe_reg <= 2'b00;
      rts_oe_reg <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        // Loop keeps the far end quiet while software self-tests
        tx_pin_reg[p] <= (loop_on[p] || ir_on[p]) ? 1'b1 : tx_line[p];
        dtr_pin_reg[p] <= !(ctrl_reg[p][`CTRL_DTR] && !loop_on[p]);
        rts_pin_reg[p] <= !(ctrl_reg[p][`CTRL_RTS] && !loop_on[p]);
        tx_oe_reg[p] <= host_bus_reset_b_in;
        dtr_oe_reg[p] <= host_bus_reset_b_in;
        rts_oe_reg[p] <= host_bus_reset_b_in;
      end
    end
  end

  // Straps follow the pins throughout host bus reset, last value kept
  always_ff @(posedge ref_clk_in) begin
    if (!host_bus_reset_b_in) begin
      strap_reg <= {rts_b_b_in, serial_tx_line_b_in, dtr_b_b_in,
                    rts_a_b_in, dtr_a_b_in, serial_tx_line_a_in};
    end
  end

  assign hrdata_out = rdata_reg;
  assign hreadyout_out = ready_reg;
  assign hresp_out = 1'b0;
  assign irq_out = irq_reg;
  assign serial_tx_line_a_out = tx_pin_reg[0];
  assign serial_tx_line_a_oe_out = tx_oe_reg[0];
  assign dtr_a_b_out = dtr_pin_reg[0];
  assign dtr_a_b_oe_out = dtr_oe_reg[0];
  assign rts_a_b_out = rts_pin_reg[0];
  assign rts_a_b_oe_out = rts_oe_reg[0];
  assign serial_tx_line_b_out = tx_pin_reg[1];
  assign serial_tx_line_b_oe_out = tx_oe_reg[1];
  assign dtr_b_b_out = dtr_pin_reg[1];
  assign dtr_b_b_oe_out = dtr_oe_reg[1];
  assign rts_b_b_out = rts_pin_reg[1];
  assign rts_b_b_oe_out = rts_oe_reg[1];

endmodule

//--- design/serial_rx_engine.sv
// Asynchronous character receiver, samples each bit at its middle
`timescale 1ns/10ps
module serial_rx_engine #(
  parameter int DATA_BITS = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire serial_port_pkg::line_cfg_t cfg_in,
  input wire logic line_in,
  output logic [DATA_BITS-1:0] data_out,
  output logic done_out,
  output logic error_out
);
  localparam int CW = $clog2(DATA_BITS + 1);
  serial_port_pkg::line_state_t state_reg;
  logic [15:0] timer_reg;
  logic [CW-1:0] count_reg;
  logic [DATA_BITS-1:0] shift_reg;
  logic parity_acc_reg;
  logic parity_err_reg;
  logic line_prev_reg;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state_reg <= serial_port_pkg::LINE_IDLE;
      timer_reg <= 16'h0000;
      count_reg <= '0;
      shift_reg <= '0;
      parity_acc_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      line_prev_reg <= 1'b1;
      data_out <= '0;
      done_out <= 1'b0;
      error_out <= 1'b0;
    end else begin
      line_prev_reg <= line_in;
      done_out <= 1'b0;
      error_out <= 1'b0;
      if (state_reg == serial_port_pkg::LINE_IDLE) begin
        if (line_prev_reg && !line_in) begin
          timer_reg <= cfg_in.divisor >> 1;
          parity_acc_reg <= cfg_in.parity_odd;
          parity_err_reg <= 1'b0;
          count_reg <= '0;
          state_reg <= serial_port_pkg::LINE_START;
        end
      end else if (timer_reg > 16'h0001) begin
        timer_reg <= timer_reg - 16'h0001;
      end else begin
        timer_reg <= cfg_in.divisor;
        case (state_reg)
          // Start bit rechecked at its middle to reject glitches
          serial_port_pkg::LINE_START: begin
            state_reg <= line_in ? serial_port_pkg::LINE_IDLE : serial_port_pkg::LINE_DATA;
          end
          serial_port_pkg::LINE_DATA: begin
            shift_reg <= {line_in, shift_reg[DATA_BITS-1:1]};
            parity_acc_reg <= parity_acc_reg ^ line_in;
            count_reg <= count_reg + CW'(1);
            if (count_reg == CW'(DATA_BITS - 1)) begin
              state_reg <= cfg_in.parity_en ? serial_port_pkg::LINE_PARITY : serial_port_pkg::LINE_STOP;
            end
          end
          serial_port_pkg::LINE_PARITY: begin
            parity_err_reg <= parity_acc_reg ^ line_in;
            state_reg <= serial_port_pkg::LINE_STOP;
          end
          serial_port_pkg::LINE_STOP: begin
            data_out <= shift_reg;
            done_out <= 1'b1;
            error_out <= parity_err_reg | !line_in;
            state_reg <= serial_port_pkg::LINE_IDLE;
          end
          default: state_reg <= serial_port_pkg::LINE_IDLE;
        endcase
      end
    end
  end
endmodule

//--- design/serial_tx_engine.sv
// Asynchronous character transmitter, one bit per divisor cycles
`timescale 1ns/10ps
module serial_tx_engine #(
  parameter int DATA_BITS = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire serial_port_pkg::line_cfg_t cfg_in,
  input wire logic start_in,
  input wire logic [DATA_BITS-1:0] data_in,
  output logic busy_out,
  output logic done_out,
  output logic line_out
);
  localparam int CW = $clog2(DATA_BITS + 1);
  serial_port_pkg::line_state_t state_reg;
  serial_port_pkg::line_cfg_t cfg_reg;
  logic [15:0] timer_reg;
  logic [CW-1:0] count_reg;
  logic [DATA_BITS-1:0] shift_reg;
  logic parity_reg;
  logic stop_left_reg;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state_reg <= serial_port_pkg::LINE_IDLE;
      cfg_reg <= '0;
      timer_reg <= 16'h0000;
      count_reg <= '0;
      shift_reg <= '0;
      parity_reg <= 1'b0;
      stop_left_reg <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      line_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      if (state_reg == serial_port_pkg::LINE_IDLE) begin
        if (start_in) begin
          // Settings latched so a mid-frame write cannot tear a character
          cfg_reg <= cfg_in;
          shift_reg <= data_in;
          parity_reg <= (^data_in) ^ cfg_in.parity_odd;
          timer_reg <= cfg_in.divisor;
          line_out <= 1'b0;
          busy_out <= 1'b1;
          state_reg <= serial_port_pkg::LINE_START;
        end
      end else if (timer_reg > 16'h0001) begin
        timer_reg <= timer_reg - 16'h0001;
      end else begin
        timer_reg <= cfg_reg.divisor;
        case (state_reg)
          serial_port_pkg::LINE_START: begin
            line_out <= shift_reg[0];
            shift_reg <= shift_reg >> 1;
            count_reg <= CW'(1);
            state_reg <= serial_port_pkg::LINE_DATA;
          end
          serial_port_pkg::LINE_DATA: begin
            if (count_reg == CW'(DATA_BITS)) begin
              line_out <= cfg_reg.parity_en ? parity_reg : 1'b1;
              stop_left_reg <= cfg_reg.two_stop;
              state_reg <= cfg_reg.parity_en ? serial_port_pkg::LINE_PARITY : serial_port_pkg::LINE_STOP;
            end else begin
              line_out <= shift_reg[0];
              shift_reg <= shift_reg >> 1;
              count_reg <= count_reg + CW'(1);
            end
          end
          serial_port_pkg::LINE_PARITY: begin
            line_out <= 1'b1;
            state_reg <= serial_port_pkg::LINE_STOP;
          end
          serial_port_pkg::LINE_STOP: begin
            if (stop_left_reg) begin
              stop_left_reg <= 1'b0;
            end else begin
              busy_out <= 1'b0;
              done_out <= 1'b1;
              state_reg <= serial_port_pkg::LINE_IDLE;
            end
          end
          default: state_reg <= serial_port_pkg::LINE_IDLE;
        endcase
      end
    end
  end
endmodule

//--- dv/modem_partner.sv
// Behavioural modem on the far side of one serial port
`timescale 1ns/10ps
module modem_partner (
  input wire logic ref_clk_in,
  input wire logic tx_pin_in,
  output logic rx_pin_out,
  output serial_port_pkg::modem_status_pins_t status_out
);
  initial begin
    rx_pin_out = 1'b1;
    status_out = 4'hF;
  end
  // Active low: a zero asserts carrier, ring, clear or ready
  task automatic set_status(input logic [3:0] s);
    @(posedge ref_clk_in);
    status_out <= s;
  endtask
  task automatic send(input logic [7:0] d, input int div);
    logic [9:0] frame;
    frame = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk_in);
      rx_pin_out <= frame[i];
      repeat (div - 1) @(posedge ref_clk_in);
    end
  endtask
  // Samples mid-bit; ok only when the stop bit is high
  task automatic recv(input int div, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    d = 8'h00;
    while (tx_pin_in !== 1'b0 && n < 80) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n < 80) begin
      repeat (div / 2) @(posedge ref_clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge ref_clk_in);
        d[i] = tx_pin_in;
      end
      repeat (div) @(posedge ref_clk_in);
      ok = tx_pin_in;
    end
  endtask
endmodule

//--- dv/serial_port_modem_pins_sva.sv
// Checker for the modem port pin behaviour
`timescale 1ns/10ps
module serial_port_modem_pins_sva (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic host_bus_reset_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic irq_out,
  input wire logic serial_tx_line_a_out,
  input wire logic serial_tx_line_b_out,
  input wire logic serial_tx_line_a_oe_out,
  input wire logic serial_tx_line_b_oe_out,
  input wire logic dtr_a_b_oe_out,
  input wire logic rts_a_b_oe_out,
  input wire logic dtr_b_b_oe_out,
  input wire logic rts_b_b_oe_out,
  input wire logic dtr_a_b_out,
  input wire logic rts_a_b_out,
  input wire logic dtr_b_b_out,
  input wire logic rts_b_b_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  logic wr_reg;
  logic [7:0] wa_reg;
  logic [5:0] oe_all;
  logic ctrl_a_wr;
  logic ctrl_b_wr;
  // Write data phase tracker: hwdata stands while wr_reg is high
  always_ff @(posedge ref_clk_in) begin
    wr_reg <= rst_b_in && hsel_in && htrans_in[1] && hready_in && hwrite_in;
    wa_reg <= haddr_in[7:0];
  end
  assign oe_all = {serial_tx_line_a_oe_out, serial_tx_line_b_oe_out, dtr_a_b_oe_out, rts_a_b_oe_out,
                   dtr_b_b_oe_out, rts_b_b_oe_out};
  assign ctrl_a_wr = wr_reg && wa_reg == 8'h00;
  assign ctrl_b_wr = wr_reg && wa_reg == 8'h20;
  sequence s_running;
    rst_b_in && host_bus_reset_b_in ##1 rst_b_in && host_bus_reset_b_in;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  property p_tx_mark; !rst_b_in |=> serial_tx_line_a_out && serial_tx_line_b_out; endproperty
  a_tx_mark: assert property (p_tx_mark) else $error("tx line not marking after reset");
  property p_dtr_idle; !rst_b_in |=> dtr_a_b_out && dtr_b_b_out; endproperty
  a_dtr_idle: assert property (p_dtr_idle) else $error("dtr active after reset");
  property p_rts_idle; !rst_b_in |=> rts_a_b_out && rts_b_b_out; endproperty
  a_rts_idle: assert property (p_rts_idle) else $error("rts active after reset");
  property p_strap_in; !host_bus_reset_b_in |=> oe_all == 6'h00; endproperty
  a_strap_in: assert property (p_strap_in) else $error("pin driven during host reset");
  property p_drive; s_running |=> oe_all == 6'h3F; endproperty
  a_drive: assert property (p_drive) else $error("pin not driven after host reset");
  property p_dtr_on;
    disable iff (!rst_b_in) ctrl_a_wr && hwdata_in[0] && !hwdata_in[4] |-> ##2 !dtr_a_b_out;
  endproperty
  a_dtr_on: assert property (p_dtr_on) else $error("dtr not active after control write");
  property p_rts_on;
    disable iff (!rst_b_in) ctrl_b_wr && hwdata_in[1] && !hwdata_in[4] && !hwdata_in[5] |-> ##2 !rts_b_b_out;
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("rts not active after control write");
  property p_loop;
    disable iff (!rst_b_in) ctrl_a_wr && hwdata_in[4] |-> ##2 (dtr_a_b_out && rts_a_b_out) [*3];
  endproperty
  a_loop: assert property (p_loop) else $error("modem outputs active in loop mode");
  property p_ir;
    disable iff (!rst_b_in) ctrl_b_wr && hwdata_in[5] |-> ##2 serial_tx_line_b_out [*8];
  endproperty
  a_ir: assert property (p_ir) else $error("port b wired line moved in infrared mode");
  c_dtr: cover property (disable iff (!rst_b_in) $fell(dtr_a_b_out));
  c_irq: cover property (disable iff (!rst_b_in) $rose(irq_out));
  c_tx: cover property (disable iff (!rst_b_in) $fell(serial_tx_line_a_out));
endmodule
bind serial_port_modem_pins serial_port_modem_pins_sva u_sva (.*);

//--- dv/serial_port_modem_pins_tb_top.sv
// Testbench for the two modem serial ports
`timescale 1ns/10ps
module serial_port_modem_pins_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic host_rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  logic [5:0] strap = 6'h2A;
  logic [31:0] rd;
  logic [5:0] pin_out;
  logic [5:0] pin_oe;
  wire [5:0] pin;
  wire rx_a;
  wire rx_b;
  serial_port_pkg::modem_status_pins_t st_a;
  serial_port_pkg::modem_status_pins_t st_b;
  int mismatches = 0;
  int compares = 0;
  always #2 ref_clk = ~ref_clk;
  // Released strap pins rest at their strap level
  assign pin = (pin_oe & pin_out) | (~pin_oe & strap);
  serial_port_modem_pins DUT (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .host_bus_reset_b_in(host_rst_b),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .irq_out(irq), .serial_tx_line_a_in(pin[0]), .serial_tx_line_a_out(pin_out[0]),
    .serial_tx_line_a_oe_out(pin_oe[0]), .serial_rx_line_a_in(rx_a), .dtr_a_b_in(pin[1]),
    .dtr_a_b_out(pin_out[1]), .dtr_a_b_oe_out(pin_oe[1]), .rts_a_b_in(pin[2]), .rts_a_b_out(pin_out[2]),
    .rts_a_b_oe_out(pin_oe[2]), .modem_a_in(st_a), .serial_tx_line_b_in(pin[4]),
    .serial_tx_line_b_out(pin_out[4]), .serial_tx_line_b_oe_out(pin_oe[4]), .serial_rx_line_b_in(rx_b),
    .dtr_b_b_in(pin[3]), .dtr_b_b_out(pin_out[3]), .dtr_b_b_oe_out(pin_oe[3]), .rts_b_b_in(pin[5]),
    .rts_b_b_out(pin_out[5]), .rts_b_b_oe_out(pin_oe[5]), .modem_b_in(st_b));
  modem_partner MA (.ref_clk_in(ref_clk), .tx_pin_in(pin[0]), .rx_pin_out(rx_a), .status_out(st_a));
  modem_partner MB (.ref_clk_in(ref_clk), .tx_pin_in(pin[4]), .rx_pin_out(rx_b), .status_out(st_b));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (n >= 40) begin
      check("bus wait", 32'h0, 32'h1);
      finish_test();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset;
    tick(1);
    check("tx idle", 32'h3, {pin_out[4], pin_out[0]});
    check("dtr rts idle", 32'hF, {pin_out[5], pin_out[3], pin_out[2], pin_out[1]});
    check("oe in host reset", 32'h0, pin_oe);
    host_rst_b <= 1'b1;
    tick(3);
    check("pins driven", 32'hFFF, {pin_oe, pin});
    ahb(1'b0, 8'h48, 32'h0);
    check("straps", 32'h2A, rd);
    ahb(1'b0, 8'h10, 32'h0);
    check("cfg reset", 32'h10, rd);
    ahb(1'b1, 8'h18, 32'hFFFF);
    ahb(1'b0, 8'h18, 32'h0);
    check("unmapped", 32'h0, rd | {31'h0, hresp});
  endtask
  task automatic sc_ctrl;
    ahb(1'b1, 8'h00, 32'h3);
    tick(2);
    check("dtr rts a on", 32'h0, {pin_out[2], pin_out[1]});
    ahb(1'b1, 8'h00, 32'h13);
    tick(2);
    check("a loop idle", 32'h3, {pin_out[2], pin_out[1]});
    ahb(1'b0, 8'h00, 32'h0);
    check("ctrl a", 32'h13, rd);
    ahb(1'b1, 8'h20, 32'h3);
    tick(2);
    check("dtr rts b on", 32'h0, {pin_out[5], pin_out[3]});
    ahb(1'b1, 8'h20, 32'h13);
    tick(2);
    check("b loop idle", 32'h3, {pin_out[5], pin_out[3]});
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b1, 8'h20, 32'h0);
  endtask
  task automatic sc_status;
    logic [3:0] s;
    for (int i = 0; i < 4; i++) begin
      s = ~(4'h1 << i);
      MA.set_status(s);
      tick(3);
      ahb(1'b0, 8'h04, 32'h0);
      check("status a", {~s[3], ~s[2], ~s[0], ~s[1], 4'h0}, rd & 32'hF0);
    end
    MB.set_status(4'h0);
    tick(3);
    ahb(1'b0, 8'h24, 32'h0);
    check("status b", 32'hF0, rd & 32'hF0);
    MA.set_status(4'hF);
    MB.set_status(4'hF);
  endtask
  task automatic sc_tx_irq;
    logic [7:0] b;
    logic ok;
    ahb(1'b1, 8'h10, 32'h4);
    ahb(1'b1, 8'h40, 32'hFF);
    ahb(1'b1, 8'h08, 32'hA5);
    MA.recv(4, b, ok);
    check("tx frame", 32'h1A5, {ok, b});
    tick(8);
    ahb(1'b0, 8'h40, 32'h0);
    check("tx done", 32'h1, rd & 32'h1);
    check("irq masked", 32'h0, irq);
    ahb(1'b1, 8'h44, 32'h1);
    tick(2);
    check("irq on", 32'h1, irq);
    ahb(1'b1, 8'h40, 32'h1);
    tick(2);
    check("irq cleared", 32'h0, irq);
    ahb(1'b1, 8'h44, 32'h0);
  endtask
  task automatic sc_rx;
    MA.send(8'h3C, 4);
    tick(8);
    ahb(1'b0, 8'h04, 32'h0);
    check("rx valid", 32'h2, rd & 32'h2);
    ahb(1'b0, 8'h0C, 32'h0);
    check("rx byte a", 32'h3C, rd);
  endtask
  task automatic sc_port_b;
    logic [7:0] b;
    logic ok;
    ahb(1'b1, 8'h30, 32'h4);
    ahb(1'b1, 8'h20, 32'h20);
    ahb(1'b1, 8'h28, 32'h5A);
    MB.recv(4, b, ok);
    check("infrared mark", 32'h0, ok);
    ahb(1'b1, 8'h20, 32'h0);
    ahb(1'b1, 8'h28, 32'h81);
    MB.recv(4, b, ok);
    check("tx frame b", 32'h181, {ok, b});
    MB.send(8'hC3, 4);
    tick(8);
    ahb(1'b0, 8'h2C, 32'h0);
    check("rx byte b", 32'hC3, rd);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    sc_reset();
    sc_ctrl();
    sc_status();
    sc_tx_irq();
    sc_rx();
    sc_port_b();
    finish_test();
  end
endmodule

//--- pkg/serial_port_defs.svh
// Offsets, field positions, reset values and counts for the modem serial ports
// How it works
// - Transmitter drives each port's serial output line
// - Receiver takes each port's serial input line
// - Master reset leaves output lines marking high
// - Port B infrared mode holds wired output marking
// - Host bus reset: output pins become strap inputs
// - Control bit zero drives terminal ready low
// - Control bit one drives request send low
// - Reset or loop keeps terminal ready high
// - Reset or loop keeps request send high
// - Status register shows current modem inputs inverted to active high
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_TXD 8'h08
`define OFF_RXD 8'h0C
`define OFF_CFG 8'h10
`define OFF_INT_STAT 8'h40
`define OFF_INT_MASK 8'h44
`define OFF_STRAPS 8'h48
`define CTRL_DTR 0
`define CTRL_RTS 1
`define CTRL_LOOP 4
`define CTRL_IR 5
`define STAT_TX_BUSY 0
`define STAT_RX_VALID 1
`define STAT_CTS 4
`define STAT_DSR 5
`define STAT_RI 6
`define STAT_DCD 7
`define CFG_PAR_EN 16
`define CFG_PAR_ODD 17
`define CFG_TWO_STOP 18
`define INT_TX_DONE 0
`define INT_RX_READY 1
`define INT_RX_ERR 2
`define INT_MODEM 3
`define INT_PER_PORT 4
`define CTRL_RESET 8'h00
`define DIVISOR_RESET 16'h0010
`endif

//--- pkg/serial_port_pkg.sv
// Types shared by the modem serial port modules
package serial_port_pkg;

  typedef struct packed {
    logic two_stop;
    logic parity_odd;
    logic parity_en;
    logic [15:0] divisor;
  } line_cfg_t;

  typedef struct packed {
    logic dcd_b;
    logic ri_b;
    logic cts_b;
    logic dsr_b;
  } modem_status_pins_t;

  typedef enum logic [2:0] {
    LINE_IDLE,
    LINE_START,
    LINE_DATA,
    LINE_PARITY,
    LINE_STOP
  } line_state_t;

endpackage
